// File: bench/meas_source.sv
// Measurement front end and blocking matrix model for the stage
// Assumes the bench sets target values whenever it likes
`default_nettype none
module meas_source #(
  parameter int TICK = 20
) (
  input wire logic ref_clk,
  input wire logic [15:0] set_rms [3],
  input wire logic [15:0] set_trms [3],
  input wire logic [15:0] set_pp [3],
  input wire logic [15:0] set_harm,
  input wire logic set_block,
  output logic [15:0] cur_rms [3],
  output logic [15:0] cur_trms [3],
  output logic [15:0] cur_pp [3],
  output logic [15:0] harm2_ratio,
  output logic block_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // New measurement values only on the refresh tick; block_in follows set_block every clock
  always @(posedge ref_clk) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      cur_rms <= set_rms;
      cur_trms <= set_trms;
      cur_pp <= set_pp;
      harm2_ratio <= set_harm;
    end
  end
  always @(posedge ref_clk) begin
    block_in <= set_block;
  end
endmodule : meas_source
`default_nettype wire

// File: bench/phase_oc_stage_asserts.sv
// Port-level checks on the phase overcurrent stage
// Assumes a bind to phase_oc_stage; one clock, sync active-low reset
`default_nettype none
module phase_oc_check (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic [2:0] phase_start,
  input wire logic [2:0] phase_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_map;
    psel && penable && paddr > 12'h024 |-> pslverr;
  endproperty
  a_map: assert property (p_map) else $error("unmapped access no error");
  property p_errdata;
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_errdata: assert property (p_errdata) else $error("unmapped read data");
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // Reset must clear start, trip, blocked and phase trip outputs even before the lag stage settles
  property p_rst;
    disable iff (1'b0) !nrst ##1 !nrst |-> !start_out && !trip_out &&
      !blocked_out && phase_trip == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  property p_excl;
    blocked_out |-> !start_out && !trip_out;
  endproperty
  a_excl: assert property (p_excl) else $error("blocked with start");
  property p_trip_ph;
    trip_out |-> phase_trip != 3'h0 && phase_start == 3'h0;
  endproperty
  a_trip_ph: assert property (p_trip_ph) else $error("trip no phase");
  property p_start_ph;
    $rose(start_out) |-> phase_start != 3'h0;
  endproperty
  a_start_ph: assert property (p_start_ph) else $error("start no phase");
  c_trip: cover property ($rose(trip_out));
  c_block: cover property ($rose(blocked_out));
  c_err: cover property (psel && penable && pslverr);
endmodule : phase_oc_check
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the phase overcurrent stage
// Assumes zero-wait APB and a 20-clock evaluation tick in simulation
`include "phase_oc_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] s_rms [3] = '{default: 16'h0000};
  logic [15:0] s_pp [3] = '{default: 16'h0000};
  logic [15:0] s_trms [3] = '{default: 16'h0000};
  logic [15:0] s_harm = 16'h0000;
  logic s_block = 1'b0;
  logic remote_wr = 1'b0;
  logic [15:0] remote_pickup = 16'h0000;
  logic [15:0] cur_rms [3];
  logic [15:0] cur_trms [3];
  logic [15:0] cur_pp [3];
  logic [15:0] harm2_ratio;
  logic block_in;
  logic start_out;
  logic trip_out;
  logic blocked_out;
  logic [2:0] phase_start;
  logic [2:0] phase_trip;
  logic [31:0] rv;
  logic err;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  meas_source #(.TICK(TICK)) src (.ref_clk(ref_clk), .set_rms(s_rms),
    .set_trms(s_trms), .set_pp(s_pp), .set_harm(s_harm),
    .set_block(s_block),
    .cur_rms(cur_rms), .cur_trms(cur_trms), .cur_pp(cur_pp),
    .harm2_ratio(harm2_ratio), .block_in(block_in));
  phase_oc_stage #(.TICK_CYCLES(TICK)) uut (.ref_clk(ref_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cur_rms(cur_rms), .cur_trms(cur_trms),
    .cur_pp(cur_pp), .harm2_ratio(harm2_ratio), .block_in(block_in),
    .remote_wr(remote_wr), .remote_pickup(remote_pickup),
    .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .phase_start(phase_start),
    .phase_trip(phase_trip));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h", $time, what, got);
    end
  endtask : chk
  task automatic pins(input logic [2:0] e, input string what);
    chk({29'h0, start_out, trip_out, blocked_out}, {29'h0, e}, what);
  endtask : pins
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rv, e, what);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n * TICK) @(posedge ref_clk);
  endtask : wt
  task automatic remote(input logic [15:0] v);
    @(posedge ref_clk);
    remote_pickup <= v;
    remote_wr <= 1'b1;
    repeat (4) @(posedge ref_clk);
    remote_wr <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : remote
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(`OC_REG_GENERAL, 32'h0000_0000, "general");
    rdc(`OC_REG_PICKUP, 32'h0000_0078, "pickup");
    rdc(`OC_REG_INRUSH, 32'h0001_0000, "inrush");
    rdc(`OC_REG_RELEASE, 32'h000c_0001, "release");
    rdc(`OC_REG_STATUS, 32'h0000_0000, "status");
    rdc(12'h030, 32'h0000_0000, "unmapped");
    chk({31'h0, err}, 32'h0000_0001, "slverr");
    wr(`OC_REG_PICKUP, 32'h0000_2000);
    rdc(`OC_REG_PICKUP, 32'h0000_1388, "clamp");
    remote(16'h01f4);
    rdc(`OC_REG_PICKUP, 32'h0000_1388, "remote off");
    wr(`OC_REG_GENERAL, 32'h0000_0001);
    remote(16'h01f4);
    rdc(`OC_REG_PICKUP, 32'h0000_01f4, "remote on");
    wr(`OC_REG_PICKUP, 32'h0000_0064);
    wr(`OC_REG_OPTIME, 32'h0000_0006);
    rdc(`OC_REG_EXPECT, 32'h0000_0006, "expect");
    rdc(`OC_REG_REMAIN, 32'h0000_0006, "remain idle");
    wr(`OC_REG_GENERAL, 32'h0000_0000);
    // Just above the setting on phase A only
    s_rms[0] <= 16'h0065;
    wt(3);
    pins(3'h4, "start");
    chk({29'h0, phase_start}, 32'h0000_0001, "ph start");
    rdc(`OC_REG_RATIO, 32'h0000_0065, "ratio");
    wt(8);
    chk({31'h0, trip_out}, 32'h0000_0001, "trip");
    chk({29'h0, phase_trip}, 32'h0000_0001, "ph trip");
    xfer(1'b0, `OC_REG_STATUS, 32'h0000_0000);
    chk(rv & 32'h0000_0003, 32'h0000_0002, "cond trip");
    rdc(`OC_REG_REMAIN, 32'h0000_0000, "remain trip");
    // Inside the hysteresis band the pick-up must hold
    s_rms[0] <= 16'h0062;
    wt(3);
    chk({31'h0, trip_out}, 32'h0000_0001, "hyst hold");
    s_rms[0] <= 16'h0060;
    wt(3);
    pins(3'h0, "hyst drop");
    s_block <= 1'b1;
    wt(2);
    s_rms[1] <= 16'h0096;
    s_rms[2] <= 16'h0096;
    wt(3);
    pins(3'h1, "blocked");
    s_block <= 1'b0;
    s_rms[1] <= 16'h0000;
    s_rms[2] <= 16'h0000;
    wt(3);
    pins(3'h0, "unblocked");
    wr(`OC_REG_RELEASE, 32'h0004_0001);
    s_rms[0] <= 16'h0096;
    wt(3);
    pins(3'h4, "start again");
    // Block well ahead of the operate delay
    s_block <= 1'b1;
    wt(3);
    pins(3'h1, "block drops start");
    wt(5);
    pins(3'h1, "released");
    s_block <= 1'b0;
    s_rms[0] <= 16'h0000;
    wt(3);
    // Plain drop with delayed release: start and phase held
    s_rms[0] <= 16'h0096;
    wt(3);
    pins(3'h4, "start no block");
    s_rms[0] <= 16'h0000;
    wt(2);
    pins(3'h4, "release hold");
    chk({29'h0, phase_start}, 32'h0000_0001, "held phase");
    wt(4);
    pins(3'h0, "release end");
    wr(`OC_REG_GENERAL, 32'h0000_0180);
    rdc(`OC_REG_GENERAL, 32'h0000_0080, "gen bits");
    s_rms[0] <= 16'h0096;
    wt(3);
    pins(3'h0, "pp ignores rms");
    s_pp[0] <= 16'h0096;
    wt(3);
    pins(3'h4, "pp start");
    s_rms[0] <= 16'h0000;
    s_pp[0] <= 16'h0000;
    wr(`OC_REG_GENERAL, 32'h0000_0000);
    wt(8);
    wr(`OC_REG_GENERAL, 32'h0000_0040);
    s_trms[0] <= 16'h0096;
    wt(3);
    pins(3'h4, "trms start");
    s_trms[0] <= 16'h0000;
    wr(`OC_REG_GENERAL, 32'h0000_0000);
    wt(8);
    wr(`OC_REG_INRUSH, 32'h0064_0001);
    s_harm <= 16'h00c8;
    s_rms[0] <= 16'h0096;
    wt(3);
    pins(3'h1, "inrush");
    s_rms[0] <= 16'h0000;
    wr(`OC_REG_INRUSH, 32'h0000_0000);
    wt(3);
    for (int c = 0; c < 4; c++) begin
      wr(`OC_REG_GENERAL, {28'h0, c[1:0], 2'h2});
      wt(2);
      xfer(1'b0, `OC_REG_STATUS, 32'h0000_0000);
      chk(rv & 32'h0000_0003, {30'h0, c[1:0]}, "forced cond");
      if (c > 0) begin
        chk({29'h0, {blocked_out, trip_out, start_out} >> (c - 1)},
          32'h0000_0001, "forced pin");
      end
    end
    wr(`OC_REG_GENERAL, 32'h0000_0000);
    conclude();
  end
endmodule : tb
bind phase_oc_stage phase_oc_check u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
  .phase_start(phase_start), .phase_trip(phase_trip));
`default_nettype wire

// File: src/phase_oc_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef PHASE_OC_MAP_SVH
`define PHASE_OC_MAP_SVH
`define OC_REG_GENERAL 12'h000
`define OC_REG_PICKUP 12'h004
`define OC_REG_INRUSH 12'h008
`define OC_REG_RELEASE 12'h00c
`define OC_REG_OPTIME 12'h010
`define OC_REG_REMOTE 12'h014
`define OC_REG_STATUS 12'h018
`define OC_REG_EXPECT 12'h01c
`define OC_REG_REMAIN 12'h020
`define OC_REG_RATIO 12'h024
// General: [0] remote allowed, [1] force enable, [5:2] force code,
// [7:6] magnitude select
`define OC_GEN_REMOTE 0
`define OC_GEN_FEN 1
`define OC_GEN_FCODE_LO 2
`define OC_GEN_MAG_LO 6
// Inrush: [0] enable, [28:16] limit in 0.01 %
`define OC_INR_EN 0
`define OC_INR_LIM_LO 16
// Release: [0] delayed release, [31:16] delay in 5 ms ticks
`define OC_REL_EN 0
`define OC_REL_TIME_LO 16
// Pick-up in 0.01 x In, default 1.20, max 50.00
`define OC_PICKUP_RST 16'h0078
`define OC_PICKUP_MAX 16'h1388
`define OC_INR_LIM_RST 13'h0001
`define OC_INR_LIM_MAX 13'h1388
`define OC_REL_TIME_RST 16'h000c
`define OC_OPTIME_RST 20'h0_0014
`define OC_TIME_MAX 20'h5_7e40
`define OC_RATIO_MAX 20'h1_e848
// Hysteresis 97 % as 97/100
`define OC_HYST_NUM 97
`define OC_HYST_DEN 100
// 5 ms tick at 100 MHz
`define OC_TICK_NS 5000000
`define OC_CLK_NS 10
`endif

// File: src/phase_oc_pkg.sv
// Types for the phase overcurrent stage
// Assumes the map header supplies all numeric constants
`default_nettype none
package phase_oc_pkg;
  typedef enum logic [1:0] {
    cond_normal,
    cond_start,
    cond_trip,
    cond_blocked
  } cond_e;
  typedef enum logic [1:0] {
    mag_rms,
    mag_trms,
    mag_pp
  } mag_e;
  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_release,
    st_tripped
  } stage_e;
endpackage : phase_oc_pkg
`default_nettype wire

// File: src/phase_oc_stage.sv
// Phase overcurrent stage with APB settings and status registers
// Assumes measurements and block input come from other clock domains
`include "phase_oc_map.svh"
`default_nettype none
module phase_oc_stage #(
  parameter int CUR_W = 16,
  parameter int TICK_CYCLES = `OC_TICK_NS / `OC_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CUR_W-1:0] cur_rms [3],
  input wire logic [CUR_W-1:0] cur_trms [3],
  input wire logic [CUR_W-1:0] cur_pp [3],
  input wire logic [CUR_W-1:0] harm2_ratio,
  input wire logic block_in,
  input wire logic remote_wr,
  input wire logic [15:0] remote_pickup,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic [2:0] phase_start,
  output logic [2:0] phase_trip
);
  initial begin
    if (CUR_W < 8 || CUR_W > 24 || TICK_CYCLES < 2) begin
      $error("phase_oc_stage: unsupported parameters");
    end
  end

  // Synchronisers for pins from other domains
  logic blk_s1_reg, blk_s2_reg;
  logic [CUR_W-1:0] r1_reg [3], r2_reg [3];
  logic [CUR_W-1:0] t1_reg [3], t2_reg [3];
  logic [CUR_W-1:0] p1_reg [3], p2_reg [3];
  logic [CUR_W-1:0] m2_reg [3];
  logic [CUR_W-1:0] h1_reg, h2_reg;

  // Settings
  logic [31:0] general_reg;
  logic [15:0] pickup_reg;
  logic inr_en_reg;
  logic [12:0] inr_lim_reg;
  logic rel_en_reg;
  logic [15:0] rel_time_reg;
  logic [19:0] optime_reg;
  logic [1:0] opt_reg;

  // Stage state
  phase_oc_pkg::stage_e state_reg, state_next;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic blk_cyc_reg;
  logic [2:0] pick_reg, pick_next;
  logic [19:0] op_cnt_reg, op_cnt_next;
  logic [15:0] rel_cnt_reg, rel_cnt_next;
  logic blocked_reg, blocked_next;
  logic [2:0] trip_ph_reg, trip_ph_next;
  logic [19:0] ratio_reg;
  logic [2:0] held_ph_reg;

  // Magnitude selection
  wire phase_oc_pkg::mag_e mag_sel =
    phase_oc_pkg::mag_e'(general_reg[`OC_GEN_MAG_LO +: 2]);
  logic [CUR_W-1:0] sel_cur [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // Select after the synchronisers so no logic reads raw pins
      sel_cur[i] = (mag_sel == phase_oc_pkg::mag_trms) ? t2_reg[i] :
                   (mag_sel == phase_oc_pkg::mag_pp) ? p2_reg[i] :
                   r2_reg[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    blk_s1_reg <= block_in;
    blk_s2_reg <= blk_s1_reg;
    h1_reg <= harm2_ratio;
    h2_reg <= h1_reg;
    for (int i = 0; i < 3; i++) begin
      r1_reg[i] <= cur_rms[i];
      r2_reg[i] <= r1_reg[i];
      t1_reg[i] <= cur_trms[i];
      t2_reg[i] <= t1_reg[i];
      p1_reg[i] <= cur_pp[i];
      p2_reg[i] <= p1_reg[i];
      m2_reg[i] <= sel_cur[i];
    end
  end

  // Program cycle tick every 5 ms
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // Pick-up compare with hysteresis; currents and setting in 0.01 x In
  wire [CUR_W+7:0] set_x100 =
    (CUR_W+8)'(pickup_reg) * (CUR_W+8)'(`OC_HYST_DEN);
  wire [CUR_W+7:0] set_x97 =
    (CUR_W+8)'(pickup_reg) * (CUR_W+8)'(`OC_HYST_NUM);
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic [CUR_W+7:0] m100;
      m100 = (CUR_W+8)'(m2_reg[i]) * (CUR_W+8)'(`OC_HYST_DEN);
      if (m100 > set_x100) begin
        pick_next[i] = 1'b1;
      end else if (m100 < set_x97) begin
        pick_next[i] = 1'b0;
      end else begin
        pick_next[i] = pick_reg[i];
      end
    end
  end
  wire any_pick = |pick_next;
  wire inrush_blk = inr_en_reg &&
    (m2_reg[0] != '0) && (32'(h2_reg) > 32'(inr_lim_reg));
  wire eff_block = blk_cyc_reg || inrush_blk;

  // Stage machine, evaluated once per tick
  always_comb begin
    state_next = state_reg;
    op_cnt_next = op_cnt_reg;
    rel_cnt_next = rel_cnt_reg;
    blocked_next = blocked_reg;
    trip_ph_next = trip_ph_reg;
    case (state_reg)
      phase_oc_pkg::st_idle: begin
        op_cnt_next = 20'h0_0000;
        if (any_pick && eff_block) begin
          blocked_next = 1'b1;
        end else if (any_pick) begin
          blocked_next = 1'b0;
          state_next = phase_oc_pkg::st_run;
          op_cnt_next = 20'h0_0001;
        end else begin
          blocked_next = 1'b0;
        end
      end
      phase_oc_pkg::st_run: begin
        if (eff_block || !any_pick) begin
          blocked_next = eff_block && any_pick;
          state_next = rel_en_reg ? phase_oc_pkg::st_release :
                       phase_oc_pkg::st_idle;
          rel_cnt_next = 16'h0000;
        end else if (op_cnt_reg >= optime_reg) begin
          state_next = phase_oc_pkg::st_tripped;
          trip_ph_next = pick_next;
        end else begin
          op_cnt_next = op_cnt_reg + 20'h0_0001;
        end
      end
      phase_oc_pkg::st_release: begin
        rel_cnt_next = rel_cnt_reg + 16'h0001;
        if (any_pick && !eff_block) begin
          state_next = phase_oc_pkg::st_run;
          blocked_next = 1'b0;
          op_cnt_next = op_cnt_reg + 20'h0_0001;
        end else if (rel_cnt_next >= rel_time_reg) begin
          state_next = phase_oc_pkg::st_idle;
          blocked_next = eff_block && any_pick;
        end
      end
      phase_oc_pkg::st_tripped: begin
        trip_ph_next = pick_next;
        if (!any_pick) begin
          state_next = phase_oc_pkg::st_idle;
        end
      end
      default: state_next = phase_oc_pkg::st_idle;
    endcase
  end

  // Highest phase and ratio
  logic [CUR_W-1:0] imax;
  always_comb begin
    imax = m2_reg[0];
    for (int i = 1; i < 3; i++) begin
      if (m2_reg[i] > imax) begin
        imax = m2_reg[i];
      end
    end
  end
  wire [31:0] ratio_calc = (pickup_reg == 16'h0000) ? 32'h0000_0000 :
    (32'(imax) * 32'h0000_0064) / 32'(pickup_reg);
  wire [19:0] ratio_sat = (ratio_calc > 32'(`OC_RATIO_MAX)) ?
    `OC_RATIO_MAX : ratio_calc[19:0];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= phase_oc_pkg::st_idle;
      pick_reg <= 3'h0;
      op_cnt_reg <= 20'h0_0000;
      rel_cnt_reg <= 16'h0000;
      blocked_reg <= 1'b0;
      trip_ph_reg <= 3'h0;
      blk_cyc_reg <= 1'b0;
      ratio_reg <= 20'h0_0000;
      held_ph_reg <= 3'h0;
    end else if (tick) begin
      blk_cyc_reg <= blk_s2_reg;
      state_reg <= state_next;
      pick_reg <= pick_next;
      op_cnt_reg <= op_cnt_next;
      rel_cnt_reg <= rel_cnt_next;
      blocked_reg <= blocked_next;
      trip_ph_reg <= trip_ph_next;
      ratio_reg <= ratio_sat;
      // Last running phases, shown while the release delay holds start
      if (state_reg == phase_oc_pkg::st_run) begin
        held_ph_reg <= pick_reg;
      end
    end
  end

  // Natural state, then forcing
  // A block entering release drops start at once; a plain drop holds it
  wire [2:0] nat_ps = (state_reg == phase_oc_pkg::st_run) ? pick_reg :
    ((state_reg == phase_oc_pkg::st_release) && !blocked_reg) ?
    held_ph_reg : 3'h0;
  wire [3:0] fcode = general_reg[`OC_GEN_FCODE_LO +: 4];
  wire force_on = general_reg[`OC_GEN_FEN] && (fcode != 4'h0);
  // Force codes: 1 start, 2 trip, 3 blocked, 4-10 start A,B,AB,C,CA,BC,ABC
  // as phase mask code-3, 11-13 trip A,B,C, 14 trip ABC
  logic [2:0] f_ps, f_pt;
  logic f_blk;
  always_comb begin
    f_ps = 3'h0;
    f_pt = 3'h0;
    f_blk = 1'b0;
    if (fcode == 4'h1) begin
      f_ps = 3'h7;
    end else if (fcode == 4'h2) begin
      f_pt = 3'h7;
    end else if (fcode == 4'h3) begin
      f_blk = 1'b1;
    end else if (fcode <= 4'ha) begin
      f_ps = 3'(fcode - 4'h3);
    end else if (fcode <= 4'hd) begin
      f_pt = 3'h1 << (fcode - 4'hb);
    end else begin
      f_pt = 3'h7;
    end
  end
  wire [2:0] ps_out = force_on ? f_ps : nat_ps;
  wire [2:0] pt_out = force_on ? f_pt : trip_ph_reg;
  wire blk_out = force_on ? f_blk : blocked_reg;
  phase_oc_pkg::cond_e cond;
  assign cond = (|pt_out) ? phase_oc_pkg::cond_trip :
    (|ps_out) ? phase_oc_pkg::cond_start :
    blk_out ? phase_oc_pkg::cond_blocked :
    phase_oc_pkg::cond_normal;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
      phase_start <= 3'h0;
      phase_trip <= 3'h0;
    end else begin
      start_out <= |ps_out;
      trip_out <= |pt_out;
      blocked_out <= blk_out;
      phase_start <= ps_out;
      phase_trip <= pt_out;
    end
  end

  // Expected and remaining time in 5 ms steps
  wire [19:0] expect_t = (optime_reg > `OC_TIME_MAX) ?
    `OC_TIME_MAX : optime_reg;
  wire [20:0] remain_t = 21'(expect_t) - 21'(op_cnt_reg);

  // APB slave, zero wait states
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_gen = (paddr == `OC_REG_GENERAL);
  wire hit_pu = (paddr == `OC_REG_PICKUP);
  wire hit_inr = (paddr == `OC_REG_INRUSH);
  wire hit_rel = (paddr == `OC_REG_RELEASE);
  wire hit_opt = (paddr == `OC_REG_OPTIME);
  wire hit_rem = (paddr == `OC_REG_REMOTE);
  wire hit_st = (paddr == `OC_REG_STATUS);
  wire hit_exp = (paddr == `OC_REG_EXPECT);
  wire hit_rmn = (paddr == `OC_REG_REMAIN);
  wire hit_rat = (paddr == `OC_REG_RATIO);
  wire hit_any = hit_gen || hit_pu || hit_inr || hit_rel || hit_opt ||
    hit_rem || hit_st || hit_exp || hit_rmn || hit_rat;
  wire [15:0] pu_wr = (pwdata[15:0] > `OC_PICKUP_MAX) ?
    `OC_PICKUP_MAX : pwdata[15:0];
  wire [15:0] pu_rem = (remote_pickup > `OC_PICKUP_MAX) ?
    `OC_PICKUP_MAX : remote_pickup;
  wire [12:0] lim_wr = (pwdata[`OC_INR_LIM_LO +: 13] > `OC_INR_LIM_MAX) ?
    `OC_INR_LIM_MAX : pwdata[`OC_INR_LIM_LO +: 13];
  wire remote_ok = general_reg[`OC_GEN_REMOTE] && remote_wr;
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      general_reg <= 32'h0000_0000;
      pickup_reg <= `OC_PICKUP_RST;
      inr_en_reg <= 1'b0;
      inr_lim_reg <= `OC_INR_LIM_RST;
      rel_en_reg <= 1'b1;
      rel_time_reg <= `OC_REL_TIME_RST;
      optime_reg <= `OC_OPTIME_RST;
      opt_reg <= 2'h0;
    end else begin
      if (wr && hit_gen) begin
        general_reg <= {24'h00_0000, pwdata[7:0]};
      end
      // Live updates apply at the next tick without restart
      if (wr && hit_pu) begin
        pickup_reg <= pu_wr;
      end else if (remote_ok) begin
        pickup_reg <= pu_rem;
      end
      if (wr && hit_inr) begin
        inr_en_reg <= pwdata[`OC_INR_EN];
        inr_lim_reg <= lim_wr;
      end
      if (wr && hit_rel) begin
        rel_en_reg <= pwdata[`OC_REL_EN];
        rel_time_reg <= pwdata[`OC_REL_TIME_LO +: 16];
      end
      if (wr && hit_opt) begin
        optime_reg <= pwdata[19:0];
      end
      if (wr && hit_rem) begin
        opt_reg <= pwdata[1:0];
      end
    end
  end

  wire [31:0] rd_mux =
    hit_gen ? general_reg :
    hit_pu ? {16'h0000, pickup_reg} :
    hit_inr ? {3'h0, inr_lim_reg, 15'h0000, inr_en_reg} :
    hit_rel ? {rel_time_reg, 15'h0000, rel_en_reg} :
    hit_opt ? {12'h000, optime_reg} :
    hit_rem ? {30'h0000_0000, opt_reg} :
    hit_st ? {16'h0000, 2'h0, state_reg, 1'b0, pt_out, 1'b0, ps_out,
              2'h0, cond} :
    hit_exp ? {12'h000, expect_t} :
    hit_rmn ? {{11{remain_t[20]}}, remain_t} :
    hit_rat ? {12'h000, ratio_reg} :
    32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
endmodule : phase_oc_stage
`default_nettype wire
